// ### pkg/bsf_regs.svh
// offsets, field positions, codes, reset values and counts of the status-flag bank
`ifndef BSF_REGS_SVH
`define BSF_REGS_SVH

// command codes of the three read-only words
`define BSF_OFS_STATUS 8'h16
`define BSF_OFS_CYCLES 8'h17
`define BSF_OFS_DESIGN_CAP 8'h18
// first code treated as reserved
`define BSF_RSVD_CODE_LO 8'h40
// data length of a word write
`define BSF_WORD_LEN 6'h02

// status word bit positions
`define BSF_BIT_OVER_CHG 15
`define BSF_BIT_TERM_CHG 14
`define BSF_BIT_RSVD_HI 13
`define BSF_BIT_OVER_TEMP 12
`define BSF_BIT_TERM_DSG 11
`define BSF_BIT_RSVD_LO 10
`define BSF_BIT_LOW_CAP 9
`define BSF_BIT_LOW_TIME 8
`define BSF_BIT_INIT 7
`define BSF_BIT_DSG 6
`define BSF_BIT_FULL_CHG 5
`define BSF_BIT_FULL_DSG 4
`define BSF_RC_MSB 2

// result codes
`define BSF_RC_OK 3'h0
`define BSF_RC_BUSY 3'h1
`define BSF_RC_RSVD 3'h2
`define BSF_RC_UNSUP 3'h3
`define BSF_RC_DENIED 3'h4
`define BSF_RC_OVFL 3'h5
`define BSF_RC_BADSIZE 3'h6
`define BSF_RC_UNKNOWN 3'h7
`define BSF_RC_ALL_ONES 16'h0007

// reset values
`define BSF_FLAG_RST 1'b0
`define BSF_WORD_RST 16'h0000
`define BSF_CYCLES_RST 16'h0000

// counts: mAh of discharge or idle before overcharge clears, clear percentage
`define BSF_OC_CLR_MAH 2'h2
`define BSF_FD_CLR_PCT 8'h14

`endif

// ### pkg/bsf_pkg.sv
// types shared by the status-flag bank
package bsf_pkg;
	`include "bsf_regs.svh"

	typedef enum logic [2:0] {
		RC_OK = `BSF_RC_OK,
		RC_BUSY = `BSF_RC_BUSY,
		RC_RSVD = `BSF_RC_RSVD,
		RC_UNSUP = `BSF_RC_UNSUP,
		RC_DENIED = `BSF_RC_DENIED,
		RC_OVFL = `BSF_RC_OVFL,
		RC_BADSIZE = `BSF_RC_BADSIZE,
		RC_UNKNOWN = `BSF_RC_UNKNOWN
	} bsf_result_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ANSWER = 2'b10
	} bsf_cmd_state_t;

	typedef struct packed {
		logic [7:0] code;
		logic write;
		logic [5:0] len;
	} bsf_cmd_t;

	typedef struct packed {
		logic charging;
		logic chg_term;
		logic dsg_or_idle_mah;
		logic removed_mah;
		logic cell_undervoltage_flag;
		logic [15:0] accum_charge;
		logic [15:0] full_cap;
		logic [15:0] remaining_charge;
		logic [15:0] voltage;
		logic [15:0] min_cell_voltage;
		logic [15:0] temperature;
		logic [15:0] current;
		logic [7:0] relative_charge_percent;
		logic [15:0] time_left_cur;
		logic [15:0] time_left_pwr;
		logic [15:0] average_time_left;
	} bsf_meas_t;

	typedef struct packed {
		logic cap_mode;
		logic [15:0] max_overcharge;
		logic [15:0] ot_chg;
		logic [15:0] ot_chg_rst;
		logic [15:0] ot_dsg;
		logic [15:0] ot_dsg_rst;
		logic [15:0] term_voltage;
		logic [15:0] suspend_temp_low;
		logic [15:0] end_voltage_level_two;
		logic [15:0] overload_current;
		logic [7:0] full_clear_pct;
		logic [7:0] batt_low_pct;
		logic [15:0] capacity_alarm_threshold;
		logic [15:0] time_alarm_threshold;
		logic [15:0] cycle_threshold;
		logic [15:0] design_cap_mah;
		logic [15:0] design_cap_10mwh;
	} bsf_limits_t;
endpackage

// ### hdl/bsf_flag.sv
// one sticky status bit with set over clear priority
`timescale 1ns/100ps
`include "bsf_regs.svh"
module bsf_flag (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic set,
	input wire logic clr,
	output logic q
);
	logic q_r;

	// set tested first so a fresh event is never lost to a clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q_r <= `BSF_FLAG_RST;
		end else if (ce) begin
			if (set) begin
				q_r <= 1'b1;
			end else if (clr) begin
				q_r <= 1'b0;
			end
		end
	end

	assign q = q_r;
endmodule

// ### hdl/bsf_cycle_ctr.sv
// saturating charge-cycle counter with nonvolatile write-back
`timescale 1ns/100ps
`include "bsf_regs.svh"
module bsf_cycle_ctr #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic removed_mah,
	input wire logic [W-1:0] threshold,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic [W-1:0] count,
	output logic nv_we,
	output logic [W-1:0] nv_data
);
	logic [W-1:0] acc_r;
	logic [W-1:0] acc_nxt;
	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;
	logic [W-1:0] nv_data_r;
	logic nv_we_r;
	logic wrap;

	// counter narrower than two bits would leave the zero pad of the increment with no bits
	if (W < 2) begin : g_chk
		$error("bsf_cycle_ctr: W must be at least 2");
	end

	// zero threshold stops counting instead of counting every mAh
	always_comb begin
		acc_nxt = acc_r + {{(W-1){1'b0}}, 1'b1};
		wrap = removed_mah && (threshold != '0) && (acc_nxt >= threshold);
		count_nxt = (count_r == '1) ? count_r : count_r + {{(W-1){1'b0}}, 1'b1};
	end

	// one count per threshold of charge removed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_r <= '0;
			count_r <= '0;
		end else if (ce) begin
			if (load) begin
				acc_r <= '0;
				count_r <= load_val;
			end else if (wrap) begin
				acc_r <= '0;
				count_r <= count_nxt;
			end else if (removed_mah) begin
				acc_r <= acc_nxt;
			end
		end
	end

	// write-back pulse only when the value really moved
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nv_we_r <= 1'b0;
			nv_data_r <= '0;
		end else if (ce) begin
			nv_we_r <= wrap && !load && (count_r != '1);
			if (wrap && !load) begin
				nv_data_r <= count_nxt;
			end
		end
	end

	assign count = count_r;
	assign nv_we = nv_we_r;
	assign nv_data = nv_data_r;
endmodule

// ### hdl/bsf_top.sv
// pack status word, alarm broadcast, cycle count and design capacity words
`timescale 1ns/100ps
`include "bsf_regs.svh"
module bsf_top (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic CE,
	input wire logic CMD_VALID,
	input wire bsf_pkg::bsf_cmd_t CMD,
	output logic CMD_READY,
	output logic RSP_VALID,
	output logic [15:0] RSP_DATA,
	input wire logic EXT_RC_VALID,
	input wire bsf_pkg::bsf_result_t EXT_RC,
	input wire logic ALARM_REQ,
	output logic ALARM_VALID,
	output logic [15:0] ALARM_WORD,
	output logic [15:0] STATUS_WORD,
	input wire bsf_pkg::bsf_meas_t MEAS,
	input wire bsf_pkg::bsf_limits_t LIMITS,
	input wire logic PARAM_LOAD_DONE,
	input wire logic PARAM_LOAD_OK,
	input wire logic [15:0] NV_CYCLES,
	output logic NV_CC_WE,
	output logic [15:0] NV_CC_DATA
);
	import bsf_pkg::*;

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [15:0] set_v;
	logic [15:0] clr_v;
	logic [15:0] flag_q;
	logic [15:0] status_comb;
	logic [15:0] design_cap;
	logic [15:0] cycles;
	logic [16:0] oc_limit;
	logic [15:0] time_est;
	logic oc_cond;
	logic oc_clear_ok;
	logic cap_rise;
	logic time_rise;
	logic temp_hot;
	logic temp_cooled;
	logic volt_low;
	logic load_good;
	logic load_bad;
	logic own_code;
	logic take;
	logic new_alarm;
	bsf_result_t cmd_rc;
	bsf_cmd_state_t state_r;
	bsf_cmd_state_t state_nxt;
	bsf_result_t rc_r;
	logic [1:0] oc_cnt_r;
	logic [15:0] rem_prev_r;
	logic [15:0] avg_prev_r;
	logic [7:0] alarm_prev_r;
	logic cmd_ready_r;
	logic rsp_valid_r;
	logic [15:0] rsp_data_r;
	logic alarm_valid_r;
	logic [15:0] alarm_word_r;
	logic [15:0] status_r;

	// ****************************************************************
	// flag conditions
	// ****************************************************************
	// 17-bit sum so a large allowed overcharge cannot wrap to zero
	always_comb begin
		oc_limit = {1'b0, MEAS.full_cap} + {1'b0, LIMITS.max_overcharge};
		oc_cond = {1'b0, MEAS.accum_charge} > oc_limit;
		oc_clear_ok = !MEAS.charging && (oc_cnt_r == `BSF_OC_CLR_MAH);
	end

	// the limit that applies follows the charge direction
	always_comb begin
		if (MEAS.charging) begin
			temp_hot = MEAS.temperature >= LIMITS.ot_chg;
			temp_cooled = MEAS.temperature < LIMITS.ot_chg_rst;
		end else begin
			temp_hot = MEAS.temperature >= LIMITS.ot_dsg;
			temp_cooled = MEAS.temperature < LIMITS.ot_dsg_rst;
		end
	end

	// estimate source chosen by capacity mode
	always_comb begin
		time_est = LIMITS.cap_mode ? MEAS.time_left_pwr : MEAS.time_left_cur;
		cap_rise = MEAS.charging && (MEAS.remaining_charge > rem_prev_r);
		time_rise = MEAS.charging && (MEAS.average_time_left > avg_prev_r);
		volt_low = (MEAS.voltage < LIMITS.end_voltage_level_two)
			|| (MEAS.min_cell_voltage < LIMITS.end_voltage_level_two);
		load_good = PARAM_LOAD_DONE && PARAM_LOAD_OK;
		load_bad = PARAM_LOAD_DONE && !PARAM_LOAD_OK;
	end

	// set and clear terms for each status bit; reserved bits stay idle
	always_comb begin
		set_v = '0;
		clr_v = '0;
		set_v[`BSF_BIT_OVER_CHG] = MEAS.charging && oc_cond;
		clr_v[`BSF_BIT_OVER_CHG] = oc_clear_ok;
		set_v[`BSF_BIT_TERM_CHG] = MEAS.chg_term;
		clr_v[`BSF_BIT_TERM_CHG] = !MEAS.charging;
		set_v[`BSF_BIT_OVER_TEMP] = temp_hot;
		clr_v[`BSF_BIT_OVER_TEMP] = temp_cooled;
		set_v[`BSF_BIT_TERM_DSG] = (MEAS.remaining_charge == '0)
			|| (MEAS.voltage <= LIMITS.term_voltage)
			|| (MEAS.temperature <= LIMITS.suspend_temp_low)
			|| MEAS.cell_undervoltage_flag;
		clr_v[`BSF_BIT_TERM_DSG] = (MEAS.voltage > LIMITS.term_voltage)
			&& (MEAS.remaining_charge != '0)
			&& !MEAS.cell_undervoltage_flag;
		// only armed while not charging, else the raise-by-charge clear would fight it
		set_v[`BSF_BIT_LOW_CAP] = !MEAS.charging
			&& (MEAS.remaining_charge < LIMITS.capacity_alarm_threshold);
		clr_v[`BSF_BIT_LOW_CAP] = cap_rise
			|| (LIMITS.capacity_alarm_threshold < MEAS.remaining_charge);
		set_v[`BSF_BIT_LOW_TIME] = !MEAS.charging
			&& (time_est < LIMITS.time_alarm_threshold);
		clr_v[`BSF_BIT_LOW_TIME] = time_rise
			|| (LIMITS.time_alarm_threshold < MEAS.average_time_left);
		set_v[`BSF_BIT_INIT] = load_good;
		clr_v[`BSF_BIT_INIT] = load_bad;
		set_v[`BSF_BIT_DSG] = !MEAS.charging;
		clr_v[`BSF_BIT_DSG] = MEAS.charging;
		set_v[`BSF_BIT_FULL_CHG] = MEAS.chg_term || oc_cond;
		clr_v[`BSF_BIT_FULL_CHG] = MEAS.relative_charge_percent
			< LIMITS.full_clear_pct;
		set_v[`BSF_BIT_FULL_DSG] = (volt_low
			&& ($signed(MEAS.current) < $signed(LIMITS.overload_current)))
			|| (MEAS.relative_charge_percent < LIMITS.batt_low_pct);
		clr_v[`BSF_BIT_FULL_DSG] = MEAS.relative_charge_percent
			>= `BSF_FD_CLR_PCT;
	end

	// ****************************************************************
	// flag storage
	// ****************************************************************
	// reserved positions and the result field get no storage at all
	for (genvar i = 0; i < 16; i++) begin : g_flag
		if (i >= `BSF_BIT_FULL_DSG && i != `BSF_BIT_RSVD_HI
			&& i != `BSF_BIT_RSVD_LO) begin : g_bit
			bsf_flag u_flag (
				.clk(CLK),
				.rst(SYS_RST),
				.ce(CE),
				.set(set_v[i]),
				.clr(clr_v[i]),
				.q(flag_q[i])
			);
		end else begin : g_zero
			assign flag_q[i] = 1'b0;
		end
	end

	// alarm and status bits above, result code in the low bits
	always_comb begin
		status_comb = flag_q;
		status_comb[`BSF_RC_MSB:0] = rc_r;
	end

	// overcharge release counter: continuous mAh since charging stopped
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			oc_cnt_r <= 2'h0;
		end else if (CE) begin
			if (MEAS.charging) begin
				oc_cnt_r <= 2'h0;
			end else if (MEAS.dsg_or_idle_mah && oc_cnt_r != `BSF_OC_CLR_MAH) begin
				oc_cnt_r <= oc_cnt_r + 2'h1;
			end
		end
	end

	// last values, to see a rise caused by charging
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rem_prev_r <= `BSF_WORD_RST;
			avg_prev_r <= `BSF_WORD_RST;
		end else if (CE) begin
			rem_prev_r <= MEAS.remaining_charge;
			avg_prev_r <= MEAS.average_time_left;
		end
	end

	// ****************************************************************
	// cycle count and design capacity
	// ****************************************************************
	bsf_cycle_ctr #(
		.W(16)
	) u_cycles (
		.clk(CLK),
		.rst(SYS_RST),
		.ce(CE),
		.removed_mah(MEAS.removed_mah),
		.threshold(LIMITS.cycle_threshold),
		.load(load_good),
		.load_val(NV_CYCLES),
		.count(cycles),
		.nv_we(NV_CC_WE),
		.nv_data(NV_CC_DATA)
	);

	// units follow capacity mode; no scaling, the word is stored per unit
	assign design_cap = LIMITS.cap_mode ? LIMITS.design_cap_10mwh
		: LIMITS.design_cap_mah;

	// ****************************************************************
	// command handling
	// ****************************************************************
	// denied checked first: a write to our code is refused whatever its length
	always_comb begin
		own_code = (CMD.code == `BSF_OFS_STATUS) || (CMD.code == `BSF_OFS_CYCLES)
			|| (CMD.code == `BSF_OFS_DESIGN_CAP);
		if (own_code && CMD.write) begin
			cmd_rc = RC_DENIED;
		end else if (CMD.code >= `BSF_RSVD_CODE_LO) begin
			cmd_rc = RC_RSVD;
		end else if (CMD.write && CMD.len != `BSF_WORD_LEN) begin
			cmd_rc = RC_BADSIZE;
		end else begin
			cmd_rc = RC_OK;
		end
		take = CMD_VALID && (state_r == ST_IDLE);
	end

	// answer state holds one cycle so a read never overlaps the next command
	always_comb begin
		case (state_r)
			ST_IDLE: begin
				if (take && own_code && !CMD.write) begin
					state_nxt = ST_ANSWER;
				end else begin
					state_nxt = ST_IDLE;
				end
			end
			ST_ANSWER: state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_r <= ST_IDLE;
			cmd_ready_r <= 1'b0;
		end else if (CE) begin
			state_r <= state_nxt;
			cmd_ready_r <= (state_nxt == ST_IDLE);
		end
	end

	// result code: own command wins over a posted code in the same cycle
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rc_r <= RC_OK;
		end else if (CE) begin
			if (CMD_VALID && state_r != ST_IDLE) begin
				rc_r <= RC_BUSY;
			end else if (take) begin
				rc_r <= cmd_rc;
			end else if (EXT_RC_VALID) begin
				rc_r <= EXT_RC;
			end
		end
	end

	// read data: status shows the code of the previous command
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rsp_valid_r <= 1'b0;
			rsp_data_r <= `BSF_WORD_RST;
		end else if (CE) begin
			rsp_valid_r <= take && own_code && !CMD.write;
			if (take && own_code && !CMD.write) begin
				case (CMD.code)
					`BSF_OFS_STATUS: rsp_data_r <= status_comb;
					`BSF_OFS_CYCLES: rsp_data_r <= cycles;
					`BSF_OFS_DESIGN_CAP: rsp_data_r <= design_cap;
					default: rsp_data_r <= `BSF_WORD_RST;
				endcase
			end
		end
	end

	// ****************************************************************
	// alarm broadcast
	// ****************************************************************
	assign new_alarm = |(status_comb[15:8] & ~alarm_prev_r);

	// sent on a fresh alarm bit or on request; result bits forced high
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			alarm_prev_r <= 8'h00;
			alarm_valid_r <= 1'b0;
			alarm_word_r <= `BSF_WORD_RST;
			status_r <= `BSF_WORD_RST;
		end else if (CE) begin
			alarm_prev_r <= status_comb[15:8];
			alarm_valid_r <= ALARM_REQ || new_alarm;
			if (ALARM_REQ || new_alarm) begin
				alarm_word_r <= status_comb | `BSF_RC_ALL_ONES;
			end
			status_r <= status_comb;
		end
	end

	assign CMD_READY = cmd_ready_r;
	assign RSP_VALID = rsp_valid_r;
	assign RSP_DATA = rsp_data_r;
	assign ALARM_VALID = alarm_valid_r;
	assign ALARM_WORD = alarm_word_r;
	assign STATUS_WORD = status_r;
endmodule

// ### verification/bsf_top_props.sv
// concurrent checks on the ports of the status-flag bank
`timescale 1ns/100ps
module bsf_top_props (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic CE,
	input wire logic CMD_VALID,
	input wire bsf_pkg::bsf_cmd_t CMD,
	input wire logic CMD_READY,
	input wire logic RSP_VALID,
	input wire logic [15:0] RSP_DATA,
	input wire logic EXT_RC_VALID,
	input wire bsf_pkg::bsf_result_t EXT_RC,
	input wire logic ALARM_REQ,
	input wire logic ALARM_VALID,
	input wire logic [15:0] ALARM_WORD,
	input wire logic [15:0] STATUS_WORD,
	input wire bsf_pkg::bsf_meas_t MEAS,
	input wire bsf_pkg::bsf_limits_t LIMITS,
	input wire logic PARAM_LOAD_DONE,
	input wire logic PARAM_LOAD_OK,
	input wire logic [15:0] NV_CYCLES,
	input wire logic NV_CC_WE,
	input wire logic [15:0] NV_CC_DATA
);
	import bsf_pkg::*;
	// ********************
	// properties
	// ********************
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);
	// accepted reads and writes of the three read-only words
	sequence s_ro_read;
		CE && CMD_VALID && CMD_READY && !CMD.write && CMD.code >= 8'h16 && CMD.code <= 8'h18;
	endsequence
	sequence s_ro_write;
		CE && CMD_VALID && CMD_READY && CMD.write && CMD.code >= 8'h16 && CMD.code <= 8'h18;
	endsequence
	// the status mirror trails each flag by one more edge
	sequence s_overcharge;
		CE && MEAS.accum_charge > 17'(MEAS.full_cap) + LIMITS.max_overcharge;
	endsequence
	chk_read_answer: assert property (s_ro_read |=> RSP_VALID && !CMD_READY)
		else $error("read of a read-only word got no answer");
	chk_write_denied: assert property (s_ro_write |=> !RSP_VALID)
		else $error("write of a read-only word was answered");
	chk_cap_by_mode: assert property (s_ro_read ##0 CMD.code == 8'h18 |=>
		RSP_DATA == ($past(LIMITS.cap_mode) ? $past(LIMITS.design_cap_10mwh) :
		$past(LIMITS.design_cap_mah)))
		else $error("capacity word does not follow the capacity mode");
	chk_alarm_ones: assert property (ALARM_VALID |-> ALARM_WORD[2:0] == 3'h7)
		else $error("broadcast word result bits not all ones");
	chk_alarm_request: assert property (CE && ALARM_REQ |=> ALARM_VALID)
		else $error("requested broadcast missing");
	chk_rsvd_zero: assert property (!STATUS_WORD[13] && !STATUS_WORD[10] && !STATUS_WORD[3])
		else $error("reserved status bit set");
	chk_dsg_idle: assert property (CE && !MEAS.charging |=> ##1 STATUS_WORD[6])
		else $error("discharging flag low while not charging");
	chk_dsg_charge: assert property (CE && MEAS.charging |=> ##1 !STATUS_WORD[6])
		else $error("discharging flag high while charging");
	chk_oc_set: assert property (s_overcharge ##0 MEAS.charging |=> ##1 STATUS_WORD[15])
		else $error("overcharge alarm not set");
	chk_full_on_oc: assert property (s_overcharge |=> ##1 STATUS_WORD[5])
		else $error("fully charged flag not set on overcharge");
	chk_busy_code: assert property (CE && CMD_VALID && !CMD_READY |=>
		##[1:2] STATUS_WORD[2:0] == 3'h1)
		else $error("refused command did not report busy");
endmodule
bind bsf_top bsf_top_props u_props (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE),
	.CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID),
	.RSP_DATA(RSP_DATA), .EXT_RC_VALID(EXT_RC_VALID), .EXT_RC(EXT_RC),
	.ALARM_REQ(ALARM_REQ), .ALARM_VALID(ALARM_VALID), .ALARM_WORD(ALARM_WORD),
	.STATUS_WORD(STATUS_WORD), .MEAS(MEAS), .LIMITS(LIMITS),
	.PARAM_LOAD_DONE(PARAM_LOAD_DONE), .PARAM_LOAD_OK(PARAM_LOAD_OK),
	.NV_CYCLES(NV_CYCLES), .NV_CC_WE(NV_CC_WE), .NV_CC_DATA(NV_CC_DATA));

// ### verification/bsf_host_model.sv
// bus host model issuing single commands to the status-flag bank
`timescale 1ns/100ps
module bsf_host_model (
	input wire logic clk,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_data,
	output bsf_pkg::bsf_cmd_t cmd,
	output logic cmd_valid
);
	import bsf_pkg::*;
	// ********************
	// command driver
	// ********************
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
	end
	// held until an edge finds the port idle; poke adds one refused command
	task automatic send(input bsf_cmd_t c, input logic poke, output logic [15:0] d,
		output logic ok);
		logic want;
		int i;
		want = !c.write && c.code >= 8'h16 && c.code <= 8'h18;
		ok = 1'b0;
		d = 16'h0000;
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd = c;
		for (i = 0; i < 20 && !ok; i++) begin
			@(posedge clk);
			ok = (cmd_ready === 1'b1);
		end
		if (poke) begin
			@(negedge clk);
			cmd = '{8'h20, 1'b1, 6'h02};
			@(posedge clk);
			want = 1'b0;
		end
		@(negedge clk);
		cmd_valid = 1'b0;
		// released fields show garbage, never the last command
		cmd = ~cmd;
		// answer looked at on falling edges, where it stands settled
		for (i = 0; i < 20 && want && ok; i++) begin
			if (rsp_valid === 1'b1) begin
				d = rsp_data;
				want = 1'b0;
			end else begin
				@(negedge clk);
			end
		end
		ok = ok && !want;
	endtask
endmodule

// ### verification/bsf_top_tb.sv
// self-checking bench of the status-flag bank
`timescale 1ns/100ps
module bsf_top_tb;
	import bsf_pkg::*;
	// ********************
	// harness
	// ********************
	logic CLK = 1'b0;
	logic SYS_RST, CE, CMD_VALID, CMD_READY, RSP_VALID, EXT_RC_VALID, ALARM_REQ, ALARM_VALID;
	logic PARAM_LOAD_DONE, PARAM_LOAD_OK, NV_CC_WE;
	logic [15:0] RSP_DATA, ALARM_WORD, STATUS_WORD, NV_CYCLES, NV_CC_DATA, d;
	bsf_cmd_t CMD;
	bsf_result_t EXT_RC;
	bsf_meas_t MEAS;
	bsf_limits_t LIMITS;
	int n_mismatch = 0;
	int checks_done = 0;
	bsf_top u_dut (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .CMD_VALID(CMD_VALID), .CMD(CMD),
		.CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
		.EXT_RC_VALID(EXT_RC_VALID), .EXT_RC(EXT_RC), .ALARM_REQ(ALARM_REQ),
		.ALARM_VALID(ALARM_VALID), .ALARM_WORD(ALARM_WORD), .STATUS_WORD(STATUS_WORD),
		.MEAS(MEAS), .LIMITS(LIMITS), .PARAM_LOAD_DONE(PARAM_LOAD_DONE),
		.PARAM_LOAD_OK(PARAM_LOAD_OK), .NV_CYCLES(NV_CYCLES), .NV_CC_WE(NV_CC_WE),
		.NV_CC_DATA(NV_CC_DATA));
	bsf_host_model u_host (.clk(CLK), .cmd_ready(CMD_READY), .rsp_valid(RSP_VALID),
		.rsp_data(RSP_DATA), .cmd(CMD), .cmd_valid(CMD_VALID));
	always #10 CLK = ~CLK;
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stall(input int i);
		if (i >= 10) begin
			n_mismatch++;
			$display("Error at %0t: handshake stalled", $time);
			close_out();
		end
	endtask
	task automatic xfer(input logic [7:0] code, input logic wr, input logic [5:0] len,
		input logic poke);
		bsf_cmd_t c;
		logic ok;
		c = '{code, wr, len};
		u_host.send(c, poke, d, ok);
		stall(ok === 1'b1 ? 0 : 10);
	endtask
	task automatic rd(input logic [7:0] code);
		xfer(code, 1'b0, 6'h00, 1'b0);
	endtask
	task automatic rc_is(input logic [2:0] exp);
		rd(8'h16);
		check({13'h0000, d[2:0]}, {13'h0000, exp});
	endtask
	// flags land one edge after their cause, the mirror one more
	task automatic settle();
		repeat (3) @(negedge CLK);
	endtask
	task automatic load(input logic good, input logic [15:0] v);
		@(negedge CLK);
		PARAM_LOAD_DONE = 1'b1;
		PARAM_LOAD_OK = good;
		NV_CYCLES = v;
		@(negedge CLK);
		PARAM_LOAD_DONE = 1'b0;
		settle();
	endtask
	task automatic wait_alarm();
		int i;
		for (i = 0; i < 10 && ALARM_VALID !== 1'b1; i++)
			@(negedge CLK);
		stall(i);
	endtask
	task automatic remove2(input logic [15:0] exp, input logic we_exp);
		int i;
		logic seen;
		seen = 1'b0;
		for (i = 0; i < 2; i++) begin
			@(negedge CLK);
			MEAS.removed_mah = 1'b1;
			@(negedge CLK);
			MEAS.removed_mah = 1'b0;
		end
		// sampled before each wait: the pulse already stands at the last drop
		for (i = 0; i < 4; i++) begin
			seen = seen | (NV_CC_WE === 1'b1);
			@(negedge CLK);
		end
		check({15'h0000, seen}, {15'h0000, we_exp});
		check(NV_CC_DATA, exp);
		rd(8'h17);
		check(d, exp);
	endtask
	// ********************
	// scenarios
	// ********************
	task automatic t_reset_state();
		rd(8'h16);
		check(d, 16'h0040);
		rd(8'h17);
		check(d, 16'h0000);
		$display("test reset_state done");
	endtask
	task automatic t_param_load();
		load(1'b1, 16'h0005);
		rd(8'h16);
		check(d, 16'h00C0);
		load(1'b0, 16'h0000);
		rd(8'h16);
		check(d, 16'h0040);
		load(1'b1, 16'h0005);
		rd(8'h17);
		check(d, 16'h0005);
		$display("test param_load done");
	endtask
	task automatic t_result_codes();
		int i;
		logic [17:0] tbl [7];
		tbl = '{{8'h16, 1'b1, 6'h02, 3'h4}, {8'h17, 1'b1, 6'h02, 3'h4},
			{8'h18, 1'b1, 6'h02, 3'h4}, {8'h20, 1'b1, 6'h03, 3'h6},
			{8'h40, 1'b0, 6'h00, 3'h2}, {8'hFF, 1'b1, 6'h02, 3'h2},
			{8'h20, 1'b1, 6'h02, 3'h0}};
		for (i = 0; i < 7; i++) begin
			xfer(tbl[i][17:10], tbl[i][9], tbl[i][8:3], 1'b0);
			rc_is(tbl[i][2:0]);
		end
		for (i = 0; i < 8; i++) begin
			@(negedge CLK);
			EXT_RC_VALID = 1'b1;
			EXT_RC = bsf_result_t'(i);
			@(negedge CLK);
			EXT_RC_VALID = 1'b0;
			rc_is(3'(i));
		end
		xfer(8'h17, 1'b0, 6'h00, 1'b1);
		rc_is(3'h1);
		rc_is(3'h0);
		$display("test result_codes done");
	endtask
	task automatic t_alarm();
		@(negedge CLK);
		ALARM_REQ = 1'b1;
		@(negedge CLK);
		ALARM_REQ = 1'b0;
		wait_alarm();
		check(ALARM_WORD, 16'h00C7);
		LIMITS.capacity_alarm_threshold = 16'h03E9;
		@(negedge CLK);
		wait_alarm();
		check(ALARM_WORD, 16'h02C7);
		LIMITS.capacity_alarm_threshold = 16'h0000;
		settle();
		rd(8'h16);
		check(d, 16'h00C0);
		$display("test alarm done");
	endtask
	task automatic t_cycles();
		remove2(16'h0006, 1'b1);
		load(1'b1, 16'hFFFE);
		remove2(16'hFFFF, 1'b1);
		remove2(16'hFFFF, 1'b0);
		$display("test cycles done");
	endtask
	task automatic t_cap();
		int m;
		for (m = 0; m < 2; m++) begin
			@(negedge CLK);
			LIMITS.cap_mode = m[0];
			settle();
			rd(8'h18);
			check(d, m[0] ? 16'h0ABC : 16'h1234);
		end
		$display("test cap done");
	endtask
	task automatic t_overcharge();
		int i;
		MEAS.charging = 1'b1;
		MEAS.accum_charge = 16'h0835;
		MEAS.chg_term = 1'b1;
		@(negedge CLK);
		MEAS.chg_term = 1'b0;
		settle();
		rd(8'h16);
		check(d, 16'hC0A0);
		MEAS.charging = 1'b0;
		MEAS.accum_charge = 16'h03E8;
		for (i = 0; i < 2; i++) begin
			MEAS.dsg_or_idle_mah = 1'b1;
			@(negedge CLK);
			MEAS.dsg_or_idle_mah = 1'b0;
			settle();
			rd(8'h16);
			check(d, i ? 16'h00E0 : 16'h80E0);
		end
		$display("test overcharge done");
	endtask
	task automatic t_limits();
		MEAS.temperature = 16'h0D02;
		settle();
		rd(8'h16);
		check(d, 16'h10E0);
		MEAS.temperature = 16'h0BA4;
		MEAS.voltage = 16'h2EE0;
		settle();
		rd(8'h16);
		check(d, 16'h08E0);
		MEAS.voltage = 16'h3E80;
		MEAS.time_left_cur = 16'h0014;
		MEAS.time_left_pwr = 16'h0005;
		LIMITS.time_alarm_threshold = 16'h000A;
		settle();
		rd(8'h16);
		check(d, 16'h01E0);
		LIMITS.cap_mode = 1'b0;
		MEAS.relative_charge_percent = 8'h04;
		settle();
		rd(8'h16);
		check(d, 16'h00D0);
		MEAS.relative_charge_percent = 8'h13;
		settle();
		rd(8'h16);
		check(d, 16'h00D0);
		MEAS.relative_charge_percent = 8'h14;
		settle();
		rd(8'h16);
		check(d, 16'h00C0);
		$display("test limits done");
	endtask
	initial begin
		SYS_RST = 1'b1;
		CE = 1'b1;
		EXT_RC_VALID = 1'b0;
		EXT_RC = RC_OK;
		ALARM_REQ = 1'b0;
		PARAM_LOAD_DONE = 1'b0;
		PARAM_LOAD_OK = 1'b0;
		NV_CYCLES = 16'h0000;
		MEAS = '{accum_charge:16'h03E8, full_cap:16'h07D0, remaining_charge:16'h03E8,
			voltage:16'h3E80, min_cell_voltage:16'h0FA0, temperature:16'h0BA4,
			relative_charge_percent:8'h32, average_time_left:16'h0064, default:'0};
		LIMITS = '{max_overcharge:16'h0064, ot_chg:16'h0C6C, ot_chg_rst:16'h0C3A,
			ot_dsg:16'h0D02, ot_dsg_rst:16'h0CD0, term_voltage:16'h2EE0,
			suspend_temp_low:16'h0AAA, end_voltage_level_two:16'h0BB8,
			overload_current:16'h1388, full_clear_pct:8'h0A, batt_low_pct:8'h05,
			cycle_threshold:16'h0002, design_cap_mah:16'h1234,
			design_cap_10mwh:16'h0ABC, default:'0};
		repeat (3) @(posedge CLK);
		@(negedge CLK);
		SYS_RST = 1'b0;
		t_reset_state();
		t_param_load();
		t_result_codes();
		t_alarm();
		t_cycles();
		t_cap();
		t_overcharge();
		t_limits();
		close_out();
	end
endmodule
